// file: src/rtfs_sequencer.sv
// transmit frame sequencer: buffer, interval timer, line coder, rf stage control
// assumes processor control bits on the core clock; stage_ready comes from analog
//
// How it works
// - hardware sends frames, timed by gated mid-frequency clock
// - frame length is field value plus one
// - bits past length ignored; start at byte zero
// - shift lsb of lowest byte first, upward
// - buffer reached as two 128-bit pages
// - start oscillator and pll, await settling before coded frames; direct mode starts without waiting
// - at end: stop, stage off, clear go
// - done interrupt only when its enable set
// - datagram repeats frame 1 to 16 times
// - two-bit code selects coding or direct mode
// - direct mode: invert bit flips data bit
// - optional two-bit carrier tail after each frame
// - gap powerdown switches oscillator and pll off in gaps between frames, not in the initial gap
// - gaps carry no carrier, like zero data
// - no random: base and frame time overlap
// - initial gap is base plus forty random
// - send automatically after gap; flag at end
// - any gap component may be zero
// - bit timing from crystal-derived tick
// - interframe gap: base plus random plus frame
// - base time counts milliseconds from mfo/125
// - seven-stage galois lfsr, advanced after use
// - frame time is unit times frame just sent
`timescale 1ns/100ps
module rtfs_sequencer #(
    parameter int unsigned HALF_BIT_CYC = rtfs_pkg::HALF_BIT_CYC_DFLT,
    parameter int unsigned MFO_CYC = rtfs_pkg::MFO_CYC,
    parameter int unsigned FIFO_DEPTH = rtfs_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // buffer access
    input wire logic buffer_page_sel_i,
    input wire logic [3:0] buf_byte_idx_i,
    input wire logic buf_wr_i,
    input wire logic [7:0] buf_wr_data_i,
    output logic [7:0] buf_rd_data_o,
    // control bits
    input wire logic tx_go_set_i,
    input wire logic tx_go_clr_i,
    input wire logic [7:0] frame_len_field_i,
    input wire logic [3:0] frame_repeat_sel_i,
    input wire logic [1:0] code_sel_i,
    input wire logic output_invert_i,
    input wire logic msg_end_tail_i,
    input wire logic gap_powerdown_i,
    input wire logic data_bit_i,
    input wire logic tx_done_irq_en_i,
    input wire logic tx_done_clr_i,
    // interval generator
    input wire logic [7:0] base_gap_field_i,
    input wire logic [5:0] frame_gap_unit_i,
    input wire logic lfsr_load_i,
    input wire logic [6:0] lfsr_seed_i,
    output logic [6:0] lfsr_o,
    // status
    output logic tx_go_o,
    output logic tx_done_flag_o,
    output logic stage_ready_o,
    output logic irq_o,
    // rf stage
    input wire logic stage_ready_i,
    output logic xtal_en_o,
    output logic pll_en_o,
    output logic pa_en_o,
    output logic mod_data_o
);
    ////////////////////////////////////////////////////////////////////////////
    // reset release and pin synchroniser
    logic rst_meta;
    logic rst_sync_b;
    logic rdy_meta;
    logic rdy_sync;

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_meta <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            rdy_meta <= 1'b0;
            rdy_sync <= 1'b0;
        end
        else
        begin
            rdy_meta <= stage_ready_i;
            rdy_sync <= rdy_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data buffer, paged for software
    logic [7:0] buf_mem [rtfs_pkg::BUF_BITS/8];
    wire [4:0] sw_byte = {buffer_page_sel_i, buf_byte_idx_i};

    always_ff @(posedge core_clk_i)
    begin
        if (buf_wr_i)
            buf_mem[sw_byte] <= buf_wr_data_i;
        buf_rd_data_o <= buf_mem[sw_byte];
    end

    ////////////////////////////////////////////////////////////////////////////
    // state and decode
    rtfs_pkg::rtfs_state_t state;
    rtfs_pkg::rtfs_state_t next_state;
    logic tx_go;
    logic first_gap;
    logic [3:0] frames_sent;
    logic [12:0] gap_cnt;
    logic [6:0] lfsr;
    logic phase;
    logic [8:0] bits_out;
    logic [8:0] push_cnt;
    logic [2:0] tail_cnt;
    logic cur_bit;
    logic bp_level;

    wire direct = (code_sel_i == rtfs_pkg::CODE_DIRECT);
    wire [8:0] frame_bits = {1'b0, frame_len_field_i} + 9'h001;
    wire in_send = (state == rtfs_pkg::ST_SEND);
    wire in_tail = (state == rtfs_pkg::ST_TAIL);
    wire in_gap = (state == rtfs_pkg::ST_GAP);

    ////////////////////////////////////////////////////////////////////////////
    // time bases: mfo runs only while go is set, bit tick from crystal rate
    logic [15:0] mfo_cnt;
    logic [6:0] ms_cnt;
    logic [15:0] bit_cnt;
    wire mfo_tick = tx_go && (mfo_cnt == 16'(MFO_CYC - 1));
    wire ms_tick = mfo_tick && (ms_cnt == 7'(rtfs_pkg::GAP_DIV - 1));
    wire coding = in_send || in_tail;
    wire half_tick = coding && (bit_cnt == 16'(HALF_BIT_CYC - 1));

    always_ff @(posedge core_clk_i or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            mfo_cnt <= '0;
            ms_cnt <= '0;
            bit_cnt <= '0;
        end
        else
        begin
            mfo_cnt <= (!tx_go || mfo_tick) ? '0 : mfo_cnt + 16'h0001;
            if (!tx_go || ms_tick)
                ms_cnt <= '0;
            else if (mfo_tick)
                ms_cnt <= ms_cnt + 7'h01;
            bit_cnt <= (!coding || half_tick) ? '0 : bit_cnt + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serializer into fifo, fifo out to line coder
    rtfs_stream_if #(.W(1)) ser ();
    rtfs_stream_if #(.W(1)) cod ();

    wire [7:0] push_idx = push_cnt[7:0];
    assign ser.valid = in_send && (push_cnt != frame_bits);
    assign ser.data = buf_mem[push_idx[7:3]][push_idx[2:0]];
    wire bit_start = half_tick && !phase && in_send;
    wire bit_end = half_tick && phase && in_send;
    assign cod.ready = bit_start;
    wire took_bit = bit_start && cod.valid;
    // close where the next bit would start, so the last bit keeps its second half
    wire frame_end = bit_start && (bits_out == frame_bits);
    wire tail_end = in_tail && half_tick && (tail_cnt == rtfs_pkg::TAIL_HALVES - 3'h1);

    rtfs_fifo #(.W(1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(core_clk_i),
        .rst_b_i(rst_sync_b),
        .wr(ser),
        .rd(cod)
    );

    ////////////////////////////////////////////////////////////////////////////
    // interval generator
    wire rand_on = (lfsr != 7'h00);
    wire [12:0] base_ms = {5'h00, base_gap_field_i};
    wire [12:0] rand_ms = {6'h00, lfsr};
    wire [3:0] frame_no = frames_sent + 4'h1;
    wire [12:0] fn_ms = 13'(frame_gap_unit_i * frame_no);
    wire [12:0] init_ms = base_ms + 13'(rand_ms * rtfs_pkg::INIT_RAND_MULT);
    wire [12:0] overlap_ms = (base_ms > fn_ms) ? base_ms : fn_ms;
    wire [12:0] ifrm_ms = rand_on ? base_ms + rand_ms + fn_ms : overlap_ms;
    wire last_frame = (frames_sent == frame_repeat_sel_i);
    wire frame_done = in_send ? (frame_end && !msg_end_tail_i) : tail_end;
    wire load_gap = (next_state == rtfs_pkg::ST_GAP) && !in_gap;
    wire [6:0] lfsr_step = {1'b0, lfsr[6:1]} ^ (lfsr[0] ? rtfs_pkg::LFSR_TAPS : 7'h00);
    wire finish = frame_done && last_frame;

    ////////////////////////////////////////////////////////////////////////////
    // sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            rtfs_pkg::ST_IDLE:
                if (tx_go)
                    next_state = direct ? rtfs_pkg::ST_DIRECT : rtfs_pkg::ST_WARM;
            rtfs_pkg::ST_WARM:
                if (rdy_sync)
                    next_state = first_gap ? rtfs_pkg::ST_GAP : rtfs_pkg::ST_SEND;
            rtfs_pkg::ST_GAP:
                if (gap_cnt == 13'h0000)
                    next_state = (!first_gap && gap_powerdown_i) ?
                        rtfs_pkg::ST_WARM : rtfs_pkg::ST_SEND;
            rtfs_pkg::ST_SEND:
                if (frame_end)
                    next_state = msg_end_tail_i ? rtfs_pkg::ST_TAIL :
                        (last_frame ? rtfs_pkg::ST_IDLE : rtfs_pkg::ST_GAP);
            rtfs_pkg::ST_TAIL:
                if (tail_end)
                    next_state = last_frame ? rtfs_pkg::ST_IDLE : rtfs_pkg::ST_GAP;
            rtfs_pkg::ST_DIRECT:
                if (!tx_go || !direct)
                    next_state = rtfs_pkg::ST_IDLE;
            default:
                next_state = rtfs_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            state <= rtfs_pkg::ST_IDLE;
            first_gap <= 1'b1;
            frames_sent <= '0;
            gap_cnt <= '0;
            lfsr <= rtfs_pkg::LFSR_RESET;
        end
        else
        begin
            state <= next_state;
            if (state == rtfs_pkg::ST_IDLE)
                first_gap <= 1'b1;
            else if (in_gap && next_state != rtfs_pkg::ST_GAP)
                first_gap <= 1'b0;
            if (state == rtfs_pkg::ST_IDLE)
                frames_sent <= '0;
            else if (frame_done)
                frames_sent <= frame_no;
            if (load_gap)
                gap_cnt <= first_gap ? init_ms : ifrm_ms;
            else if (in_gap && ms_tick && gap_cnt != 13'h0000)
                gap_cnt <= gap_cnt - 13'h0001;
            if (lfsr_load_i)
                lfsr <= lfsr_seed_i;
            else if (load_gap && rand_on)
                lfsr <= lfsr_step;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bit counters and line coder
    always_ff @(posedge core_clk_i or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            push_cnt <= '0;
            bits_out <= '0;
            phase <= 1'b0;
            tail_cnt <= '0;
            cur_bit <= 1'b0;
            bp_level <= 1'b0;
        end
        else
        begin
            if (!in_send)
                push_cnt <= '0;
            else if (ser.valid && ser.ready)
                push_cnt <= push_cnt + 9'h001;
            if (!in_send)
                bits_out <= '0;
            else if (bit_end)
                bits_out <= bits_out + 9'h001;
            if (!coding)
                phase <= 1'b0;
            else if (took_bit || bit_end || in_tail && half_tick)
                phase <= !phase;
            tail_cnt <= !in_tail ? '0 : (half_tick ? tail_cnt + 3'h1 : tail_cnt);
            if (took_bit)
            begin
                cur_bit <= cod.data;
                bp_level <= !bp_level;
            end
            else if (bit_end && !cur_bit)
                bp_level <= !bp_level;
        end
    end

    logic enc_level;
    always_comb
    begin
        case (code_sel_i)
            rtfs_pkg::CODE_MANCH: enc_level = phase ? cur_bit : !cur_bit;
            rtfs_pkg::CODE_BIPHASE: enc_level = bp_level;
            default: enc_level = cur_bit;
        endcase
    end

    // a frame only shows data once its first bit is taken, so no glitch at entry
    wire send_level = in_send && (phase || bits_out != 9'h000) && (enc_level ^ output_invert_i);
    wire next_mod = (state == rtfs_pkg::ST_DIRECT) ? (data_bit_i ^ output_invert_i) :
        (in_tail || send_level);

    ////////////////////////////////////////////////////////////////////////////
    // control flags and rf stage outputs
    wire gap_off = in_gap && !first_gap && gap_powerdown_i;
    wire next_osc = (state != rtfs_pkg::ST_IDLE) && !gap_off;
    wire next_pa = coding || (state == rtfs_pkg::ST_DIRECT);
    wire next_go = tx_go_set_i || (tx_go && !tx_go_clr_i && !finish);
    wire next_done = finish || (tx_done_flag_o && !tx_done_clr_i);

    always_ff @(posedge core_clk_i or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            tx_go <= 1'b0;
            tx_go_o <= 1'b0;
            tx_done_flag_o <= 1'b0;
            irq_o <= 1'b0;
            stage_ready_o <= 1'b0;
            xtal_en_o <= 1'b0;
            pll_en_o <= 1'b0;
            pa_en_o <= 1'b0;
            mod_data_o <= 1'b0;
            lfsr_o <= rtfs_pkg::LFSR_RESET;
        end
        else
        begin
            tx_go <= next_go;
            tx_go_o <= next_go;
            tx_done_flag_o <= next_done;
            irq_o <= next_done && tx_done_irq_en_i;
            stage_ready_o <= rdy_sync;
            xtal_en_o <= next_osc;
            pll_en_o <= next_osc;
            pa_en_o <= next_pa;
            mod_data_o <= next_pa && next_mod;
            lfsr_o <= lfsr;
        end
    end
endmodule

// file: src/rtfs_pkg.sv
// constants and types shared by the transmit frame sequencer and its fifo
// assumes a single 250 MHz core clock; no import, every use is scoped
package rtfs_pkg;
    // clock and derived time bases
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned MFO_PERIOD_NS = 8000;
    localparam int unsigned MFO_CYC = MFO_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned GAP_DIV = 125;
    localparam int unsigned HALF_BIT_CYC_DFLT = 1000;
    // buffer geometry
    localparam int unsigned BUF_BITS = 256;
    localparam int unsigned PAGE_BYTES = 16;
    localparam int unsigned FIFO_DEPTH = 8;
    // interval generator
    localparam logic [6:0] LFSR_RESET = 7'h40;
    localparam logic [6:0] LFSR_TAPS = 7'h60;
    localparam logic [12:0] INIT_RAND_MULT = 13'h028;
    localparam logic [2:0] TAIL_HALVES = 3'h4;
    // line codes
    localparam logic [1:0] CODE_MANCH = 2'h0;
    localparam logic [1:0] CODE_BIPHASE = 2'h1;
    localparam logic [1:0] CODE_NRZ = 2'h2;
    localparam logic [1:0] CODE_DIRECT = 2'h3;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_WARM = 6'h02,
        ST_GAP = 6'h04,
        ST_SEND = 6'h08,
        ST_TAIL = 6'h10,
        ST_DIRECT = 6'h20
    } rtfs_state_t;
endpackage

// file: src/rtfs_stream_if.sv
// valid/ready stream of buffer bits between serializer, fifo and line coder
// assumes both ends sit on the same clock
`timescale 1ns/100ps
interface rtfs_stream_if #(parameter int unsigned W = 1);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// file: src/rtfs_fifo.sv
// small synchronous fifo, width and depth set by parameters
// assumes one clock and an active low asynchronous reset already synchronised
`timescale 1ns/100ps
module rtfs_fifo #(
    parameter int unsigned W = 1,
    parameter int unsigned DEPTH = rtfs_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // streams
    rtfs_stream_if.snk wr,
    rtfs_stream_if.src rd
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = wr.valid && wr.ready;
    wire pop = rd.valid && rd.ready;
    wire [AW-1:0] last_ptr = AW'(DEPTH - 1);

    assign wr.ready = (count != (AW+1)'(DEPTH));
    assign rd.valid = (count != '0);
    assign rd.data = mem[rd_ptr];

    always_ff @(posedge clk_i)
    begin
        if (push)
            mem[wr_ptr] <= wr.data;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == last_ptr) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == last_ptr) ? '0 : rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// file: verif/rtfs_rf_stage_model.sv
// behavioural rf stage: crystal and pll settle, then the stage reports ready
// assumes enables from the sequencer on the core clock; ready goes to an async input
`timescale 1ns/100ps
module rtfs_rf_stage_model #(
    parameter int unsigned SETTLE = 6
) (
    // clock
    input wire logic clk_i,
    // enables from the sequencer
    input wire logic xtal_en_i,
    input wire logic pll_en_i,
    // status back to the sequencer
    output logic ready_o
);
    int unsigned cnt = 0;
    initial ready_o = 1'b0;
    // ready drops at once when power goes, so a warm restart must wait again
    always @(posedge clk_i)
    begin
        if (!(xtal_en_i && pll_en_i))
        begin
            cnt <= 0;
            ready_o <= 1'b0;
        end
        else if (cnt < SETTLE)
            cnt <= cnt + 1;
        else
            ready_o <= 1'b1;
    end
endmodule

// file: verif/rtfs_sequencer_properties.sv
// checker for the sequencer, watching only its top ports
// assumes a single core clock and the raw active low reset
`timescale 1ns/100ps
module rtfs_sequencer_properties (
    // inputs of the sequencer
    input wire logic core_clk_i, rst_b_i, tx_go_set_i, tx_go_clr_i, tx_done_irq_en_i,
    input wire logic tx_done_clr_i, data_bit_i, output_invert_i, lfsr_load_i, stage_ready_i,
    input wire logic [1:0] code_sel_i,
    input wire logic [6:0] lfsr_seed_i,
    // outputs of the sequencer
    input wire logic tx_go_o, tx_done_flag_o, irq_o, stage_ready_o, xtal_en_o, pll_en_o,
    input wire logic pa_en_o, mod_data_o,
    input wire logic [6:0] lfsr_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////////////////////////
    go_sets_a: assert property (tx_go_set_i && !tx_go_clr_i |=> tx_go_o)
        else $error("go bit did not set");
    irq_on_a: assert property (tx_done_flag_o && tx_done_irq_en_i && !tx_done_clr_i |=> irq_o)
        else $error("interrupt missing");
    irq_masked_a: assert property (!tx_done_irq_en_i |=> !irq_o)
        else $error("interrupt while disabled");
    pa_powered_a: assert property (pa_en_o |-> xtal_en_o && pll_en_o)
        else $error("output stage on without oscillator");
    done_stops_a: assert property ($rose(tx_done_flag_o) |-> ##[0:2] (!tx_go_o && !pa_en_o))
        else $error("done without stopping");
    flag_sticky_a: assert property (tx_done_flag_o && !tx_done_clr_i |=> tx_done_flag_o)
        else $error("done flag lost");
    gap_quiet_a: assert property ((!pa_en_o)[*3] |-> !mod_data_o)
        else $error("carrier while stage off");
    direct_data_a: assert property ((pa_en_o && code_sel_i == 2'h3)[*3] |->
        mod_data_o == ($past(data_bit_i, 1) ^ $past(output_invert_i, 1)))
        else $error("direct data wrong");
    ready_sync_a: assert property (stage_ready_i[*7] |-> stage_ready_o)
        else $error("stage ready not reported");
    lfsr_load_a: assert property (lfsr_load_i && !tx_go_o |=> ##1
        lfsr_o == $past(lfsr_seed_i, 2))
        else $error("lfsr seed not loaded");
endmodule

bind rtfs_sequencer rtfs_sequencer_properties rtfs_sequencer_properties_inst (.*);

// file: verif/rtfs_sequencer_tb_top.sv
// self-checking bench for the sequencer with a behavioural rf stage
// assumes short HALF_BIT_CYC and MFO_CYC so frames and gaps stay brief
`timescale 1ns/100ps
module rtfs_sequencer_tb_top;
    logic clk, rst_b, pg, wr, go_set, go_clr, inv, tail, pd, dbit, ien, dclr, lload, sready;
    logic [3:0] idx, rep;
    logic [7:0] wdata, flen, base, rd;
    logic [1:0] csel;
    logic [5:0] unit;
    logic [6:0] seed, lfsr;
    logic go, flag, srdy, irq, xtal, pll, pa, mdat;
    logic [7:0] mem [32];
    logic samp [$];
    int fails = 0;
    int n_compared = 0;
    int pa_rise = 0;
    int xtal_fall = 0;
    logic pa_q = 1'b0;
    logic xtal_q = 1'b0;
    ////////////////////////////////////////////////////////////////////////////////
    rtfs_sequencer #(.HALF_BIT_CYC(4), .MFO_CYC(2), .FIFO_DEPTH(8)) rtfs_sequencer_inst (
        .core_clk_i(clk), .rst_b_i(rst_b), .buffer_page_sel_i(pg), .buf_byte_idx_i(idx),
        .buf_wr_i(wr), .buf_wr_data_i(wdata), .buf_rd_data_o(rd), .tx_go_set_i(go_set),
        .tx_go_clr_i(go_clr), .frame_len_field_i(flen), .frame_repeat_sel_i(rep),
        .code_sel_i(csel), .output_invert_i(inv), .msg_end_tail_i(tail),
        .gap_powerdown_i(pd), .data_bit_i(dbit), .tx_done_irq_en_i(ien),
        .tx_done_clr_i(dclr), .base_gap_field_i(base), .frame_gap_unit_i(unit),
        .lfsr_load_i(lload), .lfsr_seed_i(seed), .lfsr_o(lfsr), .tx_go_o(go),
        .tx_done_flag_o(flag), .stage_ready_o(srdy), .irq_o(irq), .stage_ready_i(sready),
        .xtal_en_o(xtal), .pll_en_o(pll), .pa_en_o(pa), .mod_data_o(mdat));
    rtfs_rf_stage_model #(.SETTLE(6)) rtfs_rf_stage_model_inst (
        .clk_i(clk), .xtal_en_i(xtal), .pll_en_i(pll), .ready_o(sready));
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // the monitor keeps every cycle of the stage-on window for later judging
    always @(posedge clk)
    begin
        if (pa)
            samp.push_back(mdat);
        if (pa && !pa_q)
            pa_rise++;
        if (!xtal && xtal_q)
            xtal_fall++;
        pa_q = pa;
        xtal_q = xtal;
    end
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wait_done();
        for (int i = 0; i < 30000 && flag !== 1'b1; i++)
            tick();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_buffer();
        for (int n = 0; n < 32; n++)
        begin
            mem[n] = 8'(n * 29 + 53);
            {pg, idx} = 5'(n);
            wdata = mem[n];
            wr = 1'b1;
            tick();
        end
        wr = 1'b0;
        for (int n = 31; n >= 0; n--)
        begin
            {pg, idx} = 5'(n);
            tick(2);
            chk(rd, mem[n]);
        end
    endtask
    // one datagram of rep + 1 frames; stage-on samples are judged mid half-bit, nrz at mid-bit, bits go lsb first
    task automatic run_frame(input logic [1:0] code, input logic [7:0] len, input logic tl);
        int nb;
        logic b;
        nb = len + 1;
        csel = code;
        flen = len;
        tail = tl;
        samp.delete();
        go_set = 1'b1;
        tick();
        go_set = 1'b0;
        wait_done();
        tick();
        chk(16'(samp.size()), 16'((rep + 1) * (8 * nb + 16 * tl + 4)));
        for (int k = 0; k < nb; k++)
        begin
            b = mem[k / 8][k % 8];
            if (code == 2'h2)
                chk(samp[8 * k + 8], b);
            else if (code == 2'h0)
                chk({samp[8 * k + 6], samp[8 * k + 10]}, {b, ~b});
            else
                chk(samp[8 * k + 6] != samp[8 * k + 10], !b);
        end
        if (tl)
            chk({samp[8 * nb + 4], samp[8 * nb + 12]}, 2'h3);
        chk({go, flag, irq, pa}, {2'h1, ien, 1'b0});
        dclr = 1'b1;
        tick();
        dclr = 1'b0;
        tick(2);
        chk({flag, irq}, 2'h0);
    endtask
    task automatic test_repeats(input logic pdn);
        pa_rise = 0;
        xtal_fall = 0;
        rep = 4'h2;
        unit = 6'h01;
        pd = pdn;
        run_frame(2'h2, 8'h07, 1'b0);
        chk(16'(pa_rise), 16'h3);
        chk(16'(xtal_fall), pdn ? 16'h3 : 16'h1);
        rep = 4'h0;
        unit = 6'h00;
        pd = 1'b0;
    endtask
    task automatic test_direct();
        csel = 2'h3;
        go_set = 1'b1;
        tick();
        go_set = 1'b0;
        for (int i = 0; i < 40 && srdy !== 1'b1; i++)
            tick();
        for (int v = 0; v < 4; v++)
        begin
            {inv, dbit} = 2'(v);
            tick(4);
            chk(mdat, dbit ^ inv);
        end
        go_clr = 1'b1;
        tick();
        go_clr = 1'b0;
        tick(4);
        chk({go, pa, mdat}, 3'h0);
        inv = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_b, pg, wr, go_set, go_clr, inv, tail, pd, dbit, ien, dclr, lload} = '0;
        {idx, rep, wdata, flen, base, csel, unit, seed} = '0;
        tick(10);
        rst_b = 1'b1;
        tick(3);
        chk({lfsr, go, flag, pa, xtal}, {7'h40, 4'h0});
        lload = 1'b1;
        tick();
        lload = 1'b0;
        tick(2);
        chk(lfsr, 7'h00);
        test_buffer();
        run_frame(2'h2, 8'hff, 1'b0);
        ien = 1'b1;
        run_frame(2'h0, 8'h01, 1'b1);
        run_frame(2'h1, 8'h11, 1'b0);
        test_repeats(1'b1);
        test_repeats(1'b0);
        test_direct();
        end_of_test();
    end
    // a full run takes well under 20000 cycles
    initial
    begin
        #(4 * 60000);
        fails++;
        end_of_test();
    end
endmodule
